/* File: design/serializer_gpio_pin_control.sv */
// pin control of a link serializer: four link pins, four register pins
// assumes pins arrive unsynchronised; link frame signals are on core_clk
`timescale 1ns/1ps
`default_nettype none
module serializer_gpio_pin_control #(
  parameter bit PIN3_SWAPPED = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic loc_wr_en,
  input wire logic loc_rd_en,
  input wire logic [7:0] loc_addr,
  input wire logic [7:0] loc_wdata,
  output logic [7:0] loc_rdata,
  output logic loc_rvalid,
  input wire logic rem_wr_en,
  input wire logic rem_rd_en,
  input wire logic [7:0] rem_addr,
  input wire logic [7:0] rem_wdata,
  output logic [7:0] rem_rdata,
  output logic rem_rvalid,
  input wire logic [3:0] link_pin_i,
  output logic [3:0] link_pin_o,
  output logic [3:0] link_pin_oe,
  input wire logic [3:0] reg_pin_i,
  output logic [3:0] reg_pin_o,
  output logic [3:0] reg_pin_oe,
  output logic [3:0] i2s_audio_in,
  output logic [3:0] i2s_pin_taken,
  output logic [3:0] fwd_gpio,
  output logic [3:0] fwd_gpio_valid,
  input wire logic bc_frame_start,
  input wire logic bc_sample_valid,
  input wire logic [3:0] bc_sample,
  input wire logic [2:0] control_channel_mode_select,
  input wire logic back_channel_rate_select,
  input wire logic back_channel_high_speed_ctl,
  output logic [11:0] bc_toggle_budget_khz
);
  import gpio_pkg::*;

  localparam logic [3:0] PIN3_FWD = PIN3_SWAPPED ? CODE_BACK : CODE_FWD;
  localparam logic [3:0] PIN3_BACK = PIN3_SWAPPED ? CODE_FWD : CODE_BACK;

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_ok_n;
  logic [7:0] pin_meta_q;
  logic [7:0] pin_sync_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_ok_n = rst_sync_q[1];

  always_ff @(posedge core_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      pin_meta_q <= 8'h00;
      pin_sync_q <= 8'h00;
    end else begin
      pin_meta_q <= {reg_pin_i, link_pin_i};
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] cfg_q [0:4];
  logic [7:0] cfg_d [0:4];
  logic [7:0] cfg_addr [0:4];

  assign cfg_addr[0] = ADDR_LINK_PIN0_CFG;
  assign cfg_addr[1] = ADDR_LINK_PIN1_2_CFG;
  assign cfg_addr[2] = ADDR_LINK_PIN3_CFG;
  assign cfg_addr[3] = ADDR_LOCAL_PIN5_6_CFG;
  assign cfg_addr[4] = ADDR_LOCAL_PIN7_8_CFG;

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      cfg_d[i] = cfg_q[i];
      if (loc_wr_en && loc_addr == cfg_addr[i]) begin
        cfg_d[i] = loc_wdata;
      end else if (rem_wr_en && rem_addr == cfg_addr[i]) begin
        cfg_d[i] = rem_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      for (int i = 0; i < 5; i++) begin
        cfg_q[i] <= CFG_RESET;
      end
    end else begin
      for (int i = 0; i < 5; i++) begin
        cfg_q[i] <= cfg_d[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // field decoders
  // ----------------------------------------------------------------
  logic [3:0] field [0:7];
  pin_cfg_if pin_cfg [0:7] ();

  assign field[0] = cfg_q[0][LO_FIELD_LSB +: 4];
  assign field[1] = cfg_q[1][LO_FIELD_LSB +: 4];
  assign field[2] = cfg_q[1][HI_FIELD_LSB +: 4];
  assign field[3] = cfg_q[2][LO_FIELD_LSB +: 4];
  assign field[4] = cfg_q[3][LO_FIELD_LSB +: 4];
  assign field[5] = cfg_q[3][HI_FIELD_LSB +: 4];
  assign field[6] = cfg_q[4][LO_FIELD_LSB +: 4];
  assign field[7] = cfg_q[4][HI_FIELD_LSB +: 4];

  generate
    for (genvar p = 0; p < 3; p++) begin : g_link
      pin_field_decode #(.FWD_CODE(CODE_FWD), .BACK_CODE(CODE_BACK)) u_dec (
        .code(field[p]),
        .cfg(pin_cfg[p])
      );
    end
    for (genvar p = 4; p < 8; p++) begin : g_local
      pin_field_decode #(.FWD_CODE(CODE_NONE), .BACK_CODE(CODE_NONE)) u_dec (
        .code(field[p]),
        .cfg(pin_cfg[p])
      );
    end
  endgenerate

  pin_field_decode #(.FWD_CODE(PIN3_FWD), .BACK_CODE(PIN3_BACK)) u_dec3 (
    .code(field[3]),
    .cfg(pin_cfg[3])
  );

  logic [7:0] drive_en;
  logic [7:0] drive_high;
  logic [7:0] from_back;
  logic [7:0] forward;
  logic [7:0] reg_mode;

  generate
    for (genvar p = 0; p < 8; p++) begin : g_flat
      assign drive_en[p] = pin_cfg[p].drive_en;
      assign drive_high[p] = pin_cfg[p].drive_high;
      assign from_back[p] = pin_cfg[p].from_back;
      assign forward[p] = pin_cfg[p].forward;
      assign reg_mode[p] = pin_cfg[p].reg_mode;
    end
  endgenerate

  // ----------------------------------------------------------------
  // back channel samples
  // ----------------------------------------------------------------
  logic [3:0] bc_count_q;
  logic [3:0] bc_count_d;
  logic [3:0] bc_val_q;
  logic [3:0] bc_val_d;
  logic [3:0] bc_limit;
  logic [3:0] bc_mask;
  logic [3:0] bc_count_now;

  always_comb begin
    bc_limit = 4'h0;
    bc_mask = 4'h0;
    case (control_channel_mode_select)
      CCM_NORMAL: begin
        bc_limit = SAMPLES_NORMAL;
        bc_mask = 4'hf;
      end
      CCM_FAST4: begin
        bc_limit = SAMPLES_FAST4;
        bc_mask = 4'hf;
      end
      CCM_FAST2: begin
        bc_limit = SAMPLES_FAST2;
        bc_mask = 4'h3;
      end
      CCM_FAST1: begin
        bc_limit = SAMPLES_FAST1;
        bc_mask = 4'h1;
      end
      default: begin
        bc_limit = 4'h0;
        bc_mask = 4'h0;
      end
    endcase
  end

  always_comb begin
    bc_count_now = bc_frame_start ? 4'h0 : bc_count_q;
    bc_count_d = bc_count_now;
    bc_val_d = bc_val_q;
    // frames also hold control traffic and CRC, handled upstream
    if (bc_sample_valid && bc_count_now < bc_limit) begin
      bc_count_d = bc_count_now + 4'h1;
      bc_val_d = (bc_val_q & ~bc_mask) | (bc_sample & bc_mask);
    end
  end

  always_ff @(posedge core_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      bc_count_q <= 4'h0;
      bc_val_q <= 4'h0;
    end else begin
      bc_count_q <= bc_count_d;
      bc_val_q <= bc_val_d;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers, forward samples, audio override, budget
  // ----------------------------------------------------------------
  logic [3:0] link_o_d;
  logic [3:0] reg_o_d;
  logic [3:0] fwd_d;
  logic [3:0] audio_d;
  logic [31:0] kbps;
  logic [31:0] budget;

  always_comb begin
    for (int p = 0; p < 4; p++) begin
      link_o_d[p] = from_back[p] ? bc_val_q[p] : drive_high[p];
      fwd_d[p] = forward[p] & pin_sync_q[p];
      reg_o_d[p] = drive_high[p + 4];
      audio_d[p] = reg_mode[p + 4] ? 1'b0 : pin_sync_q[p + 4];
    end
  end

  always_comb begin
    if (back_channel_high_speed_ctl) begin
      kbps = 32'(BC_RATE_HIGH_KBPS);
    end else if (back_channel_rate_select) begin
      kbps = 32'(BC_RATE_MID_KBPS);
    end else begin
      kbps = 32'(BC_RATE_LOW_KBPS);
    end
    budget = kbps * 32'(100 - BC_SLOW_PCT) * 32'(bc_limit)
      / 32'(100 * BC_FRAME_BITS * BC_OVERSAMPLE);
  end

  always_ff @(posedge core_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      link_pin_o <= 4'h0;
      link_pin_oe <= 4'h0;
      reg_pin_o <= 4'h0;
      reg_pin_oe <= 4'h0;
      fwd_gpio <= 4'h0;
      fwd_gpio_valid <= 4'h0;
      i2s_audio_in <= 4'h0;
      i2s_pin_taken <= 4'h0;
      bc_toggle_budget_khz <= 12'h000;
    end else begin
      link_pin_o <= link_o_d;
      link_pin_oe <= drive_en[3:0];
      reg_pin_o <= reg_o_d;
      reg_pin_oe <= drive_en[7:4];
      fwd_gpio <= fwd_d;
      fwd_gpio_valid <= forward[3:0];
      i2s_audio_in <= audio_d;
      i2s_pin_taken <= reg_mode[7:4];
      bc_toggle_budget_khz <= budget[11:0];
    end
  end

  // ----------------------------------------------------------------
  // register reads, one port each
  // ----------------------------------------------------------------
  logic [7:0] loc_rdata_d;
  logic [7:0] rem_rdata_d;

  function automatic logic [7:0] read_reg(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 5; i++) begin
      if (a == cfg_addr[i]) begin
        r = cfg_q[i];
      end
    end
    if (a == ADDR_PIN_INPUT_LEVELS) begin
      r[LINK_LVL_LSB +: 4] = pin_sync_q[3:0];
      r[LOCAL_LVL_LSB +: 3] = pin_sync_q[6:4];
    end else if (a == ADDR_PIN8_INPUT_LEVEL) begin
      r[PIN8_LVL_BIT] = pin_sync_q[7];
    end
    return r;
  endfunction

  always_comb begin
    loc_rdata_d = loc_rd_en ? read_reg(loc_addr) : loc_rdata;
    rem_rdata_d = rem_rd_en ? read_reg(rem_addr) : rem_rdata;
  end

  always_ff @(posedge core_clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      loc_rdata <= 8'h00;
      rem_rdata <= 8'h00;
      loc_rvalid <= 1'b0;
      rem_rvalid <= 1'b0;
    end else begin
      loc_rdata <= loc_rdata_d;
      rem_rdata <= rem_rdata_d;
      loc_rvalid <= loc_rd_en;
      rem_rvalid <= rem_rd_en;
    end
  end
endmodule // serializer_gpio_pin_control
`default_nettype wire

/* File: pkg/gpio_pkg.sv */
// constants for the serializer pin control block
// assumes byte-wide registers reached by address from a local and a remote port
package gpio_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LINK_PIN0_CFG = 8'h0d;
  localparam logic [7:0] ADDR_LINK_PIN1_2_CFG = 8'h0e;
  localparam logic [7:0] ADDR_LINK_PIN3_CFG = 8'h0f;
  localparam logic [7:0] ADDR_LOCAL_PIN5_6_CFG = 8'h10;
  localparam logic [7:0] ADDR_LOCAL_PIN7_8_CFG = 8'h11;
  localparam logic [7:0] ADDR_PIN_INPUT_LEVELS = 8'h1c;
  localparam logic [7:0] ADDR_PIN8_INPUT_LEVEL = 8'h1d;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LO_FIELD_LSB = 0;
  localparam int HI_FIELD_LSB = 4;
  localparam int LINK_LVL_LSB = 0;
  localparam int LOCAL_LVL_LSB = 5;
  localparam int PIN8_LVL_BIT = 0;
  // ----------------------------------------------------------------
  // pin field codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CODE_OUT_LOW = 4'h1;
  localparam logic [3:0] CODE_OUT_HIGH = 4'h9;
  localparam logic [3:0] CODE_INPUT = 4'h3;
  localparam logic [3:0] CODE_FWD = 4'h3;
  localparam logic [3:0] CODE_BACK = 4'h5;
  localparam logic [3:0] CODE_NONE = 4'h0;
  // ----------------------------------------------------------------
  // back channel modes and budget
  // ----------------------------------------------------------------
  localparam logic [2:0] CCM_NORMAL = 3'h0;
  localparam logic [2:0] CCM_FAST4 = 3'h3;
  localparam logic [2:0] CCM_FAST2 = 3'h2;
  localparam logic [2:0] CCM_FAST1 = 3'h1;
  localparam logic [3:0] SAMPLES_NORMAL = 4'h1;
  localparam logic [3:0] SAMPLES_FAST4 = 4'h6;
  localparam logic [3:0] SAMPLES_FAST2 = 4'ha;
  localparam logic [3:0] SAMPLES_FAST1 = 4'hf;
  localparam int BC_RATE_LOW_KBPS = 5000;
  localparam int BC_RATE_MID_KBPS = 10000;
  localparam int BC_RATE_HIGH_KBPS = 20000;
  localparam int BC_SLOW_PCT = 20;
  localparam int BC_OVERSAMPLE = 4;
  localparam int BC_FRAME_BITS = 30;
endpackage

/* File: pkg/pin_cfg_if.sv */
// decoded behaviour of one pin field
// assumes the decoder drives it and the pin logic reads it
`timescale 1ns/1ps
`default_nettype none
interface pin_cfg_if;
  logic drive_en;
  logic drive_high;
  logic from_back;
  logic forward;
  logic reg_mode;
  modport decoder (output drive_en, drive_high, from_back, forward, reg_mode);
  modport user (input drive_en, drive_high, from_back, forward, reg_mode);
endinterface
`default_nettype wire

/* File: design/pin_field_decode.sv */
// decoder of one four-bit pin field
// assumes link pins pass their forward and back codes, local pins CODE_NONE
`timescale 1ns/1ps
`default_nettype none
module pin_field_decode #(
  parameter logic [3:0] FWD_CODE = gpio_pkg::CODE_FWD,
  parameter logic [3:0] BACK_CODE = gpio_pkg::CODE_BACK
) (
  input wire logic [3:0] code,
  pin_cfg_if.decoder cfg
);
  import gpio_pkg::*;

  always_comb begin
    cfg.drive_en = 1'b0;
    cfg.drive_high = 1'b0;
    cfg.from_back = 1'b0;
    cfg.forward = 1'b0;
    cfg.reg_mode = 1'b0;
    if (code == CODE_OUT_LOW) begin
      cfg.drive_en = 1'b1;
      cfg.reg_mode = 1'b1;
    end else if (code == CODE_OUT_HIGH) begin
      cfg.drive_en = 1'b1;
      cfg.drive_high = 1'b1;
      cfg.reg_mode = 1'b1;
    end else if (BACK_CODE != CODE_NONE && code == BACK_CODE) begin
      cfg.drive_en = 1'b1;
      cfg.from_back = 1'b1;
    end else if (FWD_CODE != CODE_NONE && code == FWD_CODE) begin
      cfg.forward = 1'b1;
    end else if (code == CODE_INPUT) begin
      cfg.reg_mode = 1'b1;
    end
    // any other code leaves the pin undriven and off the link
  end
endmodule // pin_field_decode
`default_nettype wire

/* File: testbench/des_model.sv */
// deserializer side of the back channel
// assumes the bench calls its tasks; drives on core_clk rising edges
`timescale 1ns/1ps
`default_nettype none
module des_model (
  input wire logic core_clk,
  output logic bc_frame_start,
  output logic bc_sample_valid,
  output logic [3:0] bc_sample,
  output logic [2:0] control_channel_mode_select,
  output logic back_channel_rate_select,
  output logic back_channel_high_speed_ctl
);
  initial begin
    bc_frame_start = 1'b0;
    bc_sample_valid = 1'b0;
    bc_sample = 4'h5;
    control_channel_mode_select = 3'h0;
    back_channel_rate_select = 1'b0;
    back_channel_high_speed_ctl = 1'b0;
  end
  // pin mode and line rate
  task automatic set_mode(input logic [2:0] m, input logic r, input logic h);
    @(posedge core_clk);
    control_channel_mode_select <= m;
    back_channel_rate_select <= r;
    back_channel_high_speed_ctl <= h;
  endtask
  // one frame of n samples, only the last one differs
  task automatic frame(input int n, input logic [3:0] v0,
                       input logic [3:0] v1);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      bc_frame_start <= (i == 0);
      bc_sample_valid <= 1'b1;
      bc_sample <= (i == n - 1) ? v1 : v0;
    end
    @(posedge core_clk);
    bc_frame_start <= 1'b0;
    bc_sample_valid <= 1'b0;
    bc_sample <= ~v1;
  endtask
endmodule // des_model
`default_nettype wire

/* File: testbench/gpio_pin_chk.sv */
// assertions on the pin control block ports
// assumes binding to serializer_gpio_pin_control
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic loc_rd_en,
  input wire logic loc_rvalid,
  input wire logic rem_rd_en,
  input wire logic rem_rvalid,
  input wire logic loc_wr_en,
  input wire logic [7:0] loc_addr,
  input wire logic [7:0] loc_wdata,
  input wire logic [3:0] reg_pin_o,
  input wire logic [3:0] reg_pin_oe,
  input wire logic [3:0] i2s_audio_in,
  input wire logic [3:0] i2s_pin_taken,
  input wire logic [3:0] link_pin_oe,
  input wire logic [3:0] fwd_gpio,
  input wire logic [3:0] fwd_gpio_valid,
  input wire logic [2:0] control_channel_mode_select,
  input wire logic back_channel_rate_select,
  input wire logic back_channel_high_speed_ctl,
  input wire logic [11:0] bc_toggle_budget_khz
);
  logic [2:0] up_q, up_d;
  logic rdy;
  always_comb up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) up_q <= 3'h0;
    else up_q <= up_d;
  assign rdy = (up_q >= 3'h4);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_LOC_RVALID: assert property (loc_rd_en |=> loc_rvalid)
    else $error("local read without rvalid");
  AST_REM_RVALID: assert property (rem_rd_en |=> rem_rvalid)
    else $error("remote read without rvalid");
  AST_NO_RVALID: assert property (rdy && !loc_rd_en |=> !loc_rvalid)
    else $error("spurious local rvalid");
  AST_AUDIO: assert property ((i2s_pin_taken & i2s_audio_in) == 4'h0)
    else $error("audio input not replaced");
  AST_REG_OE: assert property ((reg_pin_oe & ~i2s_pin_taken) == 4'h0)
    else $error("register pin driven outside pin mode");
  AST_FWD_UNDRIVEN: assert property ((link_pin_oe & fwd_gpio_valid) == 4'h0)
    else $error("forward pin driven");
  AST_FWD_GATED: assert property ((fwd_gpio & ~fwd_gpio_valid) == 4'h0)
    else $error("sample sent for non forward pin");
  AST_OUT_HIGH: assert property (loc_wr_en && loc_addr == 8'h10 &&
    loc_wdata[3:0] == 4'h9 |-> ##2 reg_pin_oe[0] && reg_pin_o[0])
    else $error("pin 5 not driven high");
  AST_BUDGET_NORMAL: assert property (rdy &&
    control_channel_mode_select == 3'h0 && !back_channel_rate_select &&
    !back_channel_high_speed_ctl |=> bc_toggle_budget_khz == 12'h021)
    else $error("normal mode budget wrong");
  AST_BUDGET_FAST1: assert property (rdy &&
    control_channel_mode_select == 3'h1 && back_channel_high_speed_ctl
    |=> bc_toggle_budget_khz == 12'h7d0)
    else $error("one pin fast budget wrong");
  AST_BUDGET_OTHER: assert property (rdy &&
    control_channel_mode_select[2] |=> bc_toggle_budget_khz == 12'h000)
    else $error("budget for unknown mode");
endmodule // gpio_pin_chk
bind serializer_gpio_pin_control gpio_pin_chk i_gpio_pin_chk (.core_clk,
  .rst_n, .loc_rd_en, .loc_rvalid, .rem_rd_en, .rem_rvalid, .loc_wr_en,
  .loc_addr, .loc_wdata, .reg_pin_o, .reg_pin_oe, .i2s_audio_in,
  .i2s_pin_taken, .link_pin_oe, .fwd_gpio, .fwd_gpio_valid,
  .control_channel_mode_select, .back_channel_rate_select,
  .back_channel_high_speed_ctl, .bc_toggle_budget_khz);
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench of the pin control block
// assumes des_model drives the back channel
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gpio_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0;
  logic loc_wr_en = 1'b0, loc_rd_en = 1'b0;
  logic rem_wr_en = 1'b0, rem_rd_en = 1'b0;
  logic [7:0] loc_addr = 8'h00, loc_wdata = 8'h00;
  logic [7:0] rem_addr = 8'h00, rem_wdata = 8'h00;
  logic [7:0] loc_rdata, rem_rdata;
  logic loc_rvalid, rem_rvalid, bc_frame_start, bc_sample_valid;
  logic back_channel_rate_select, back_channel_high_speed_ctl;
  logic [3:0] link_pin_i, link_pin_o, link_pin_oe, bc_sample;
  logic [3:0] reg_pin_i, reg_pin_o, reg_pin_oe, i2s_audio_in;
  logic [3:0] i2s_pin_taken, fwd_gpio, fwd_gpio_valid, rw;
  logic [3:0] ext_link = 4'h0, ext_reg = 4'h0;
  logic [2:0] control_channel_mode_select;
  logic [11:0] bc_toggle_budget_khz;
  logic on, hi, tk;
  int error_cnt = 0, checks_done = 0;
  logic [7:0] addrs [7] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h1c, 8'h1d};
  logic [3:0] codes [5] = '{4'h1, 4'h9, 4'h3, 4'h0, 4'h7};
  logic [2:0] bm [8] = '{3'h0, 3'h0, 3'h3, 3'h3, 3'h2, 3'h2, 3'h1, 3'h1};
  int bn [8] = '{1, 2, 6, 7, 10, 11, 15, 16};
  logic [3:0] bx [8] = '{4'hf, 4'h0, 4'hf, 4'h0, 4'h3, 4'h0, 4'h1, 4'h0};
  // toggle budget in kHz: row by mode code, column by 5, 10, 20 Mbps
  int bud [4][3] = '{'{33, 66, 133}, '{500, 1000, 2000}, '{333, 666, 1333},
    '{200, 400, 800}};
  assign link_pin_i = (link_pin_oe & link_pin_o) | (~link_pin_oe & ext_link);
  assign reg_pin_i = (reg_pin_oe & reg_pin_o) | (~reg_pin_oe & ext_reg);
  always #2.5 core_clk = ~core_clk;
  serializer_gpio_pin_control i_serializer_gpio_pin_control (.core_clk,
    .rst_n, .loc_wr_en, .loc_rd_en, .loc_addr, .loc_wdata, .loc_rdata,
    .loc_rvalid, .rem_wr_en, .rem_rd_en, .rem_addr, .rem_wdata, .rem_rdata,
    .rem_rvalid, .link_pin_i, .link_pin_o, .link_pin_oe, .reg_pin_i,
    .reg_pin_o, .reg_pin_oe, .i2s_audio_in, .i2s_pin_taken, .fwd_gpio,
    .fwd_gpio_valid, .bc_frame_start, .bc_sample_valid, .bc_sample,
    .control_channel_mode_select, .back_channel_rate_select,
    .back_channel_high_speed_ctl, .bc_toggle_budget_khz);
  des_model i_des_model (.core_clk, .bc_frame_start, .bc_sample_valid,
    .bc_sample, .control_channel_mode_select, .back_channel_rate_select,
    .back_channel_high_speed_ctl);
  // ----
  // tasks
  // ----
  task automatic close_out();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t byte %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t budget %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input bit rem, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    loc_wr_en <= !rem;
    rem_wr_en <= rem;
    loc_addr <= a;
    rem_addr <= a;
    loc_wdata <= d;
    rem_wdata <= d;
    @(posedge core_clk);
    loc_wr_en <= 1'b0;
    rem_wr_en <= 1'b0;
  endtask
  task automatic rchk(input bit rem, input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    loc_rd_en <= !rem;
    rem_rd_en <= rem;
    loc_addr <= a;
    rem_addr <= a;
    @(posedge core_clk);
    loc_rd_en <= 1'b0;
    rem_rd_en <= 1'b0;
    @(negedge core_clk);
    chk_reg({7'h00, rem ? rem_rvalid : loc_rvalid}, 8'h01);
    chk_reg(rem ? rem_rdata : loc_rdata, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  function automatic int budget(input int m, input int r);
    int j;
    j = r[1] ? 2 : int'(r[0]);
    return (m < 4) ? bud[m][j] : 0;
  endfunction
  // ----
  // tests
  // ----
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    foreach (addrs[i]) rchk(i[0], addrs[i], 8'h00);
    wr(0, 8'h0e, 8'h53);
    rchk(1, 8'h0e, 8'h53);
    @(posedge core_clk);
    ext_link <= 4'ha;
    ext_reg <= 4'hd;
    wr(1, 8'h0e, 8'h00);
    wr(0, 8'h1c, 8'hff);
    rchk(0, 8'h1c, {ext_reg[2:0], 1'b0, ext_link});
    rchk(0, 8'h12, 8'h00);
    foreach (codes[i]) begin
      wr(!i[0], 8'h10, {2{codes[i]}});
      wr(i[0], 8'h11, {2{codes[i]}});
      on = (codes[i] == 4'h1) || (codes[i] == 4'h9);
      hi = (codes[i] == 4'h9);
      tk = on || (codes[i] == 4'h3);
      rw = on ? {4{hi}} : ext_reg;
      settle(3);
      chk_reg({reg_pin_oe, reg_pin_o}, {{4{on}}, {4{hi}}});
      chk_reg({i2s_pin_taken, i2s_audio_in}, {{4{tk}}, tk ? 4'h0 : rw});
      rchk(0, 8'h1c, {rw[2:0], 1'b0, ext_link});
      rchk(1, 8'h1d, {7'h00, rw[3]});
    end
    @(posedge core_clk);
    ext_link <= 4'h9;
    wr(0, 8'h0d, 8'h03);
    wr(1, 8'h0e, 8'h19);
    wr(0, 8'h0f, 8'h05);
    settle(5);
    chk_reg({fwd_gpio_valid, fwd_gpio}, 8'h99);
    chk_reg({link_pin_oe, link_pin_o}, 8'h62);
    wr(0, 8'h0d, 8'h0b);
    settle(5);
    chk_reg({fwd_gpio_valid, fwd_gpio}, 8'h88);
    chk_reg({4'h0, link_pin_oe}, 8'h06);
    wr(0, 8'h0d, 8'h05);
    wr(0, 8'h0e, 8'h55);
    wr(0, 8'h0f, 8'h03);
    foreach (bm[i]) begin
      i_des_model.set_mode(bm[i], 1'b0, 1'b0);
      i_des_model.frame(bn[i], 4'h0, 4'hf);
      settle(3);
      chk_reg({link_pin_oe, link_pin_o}, {4'hf, bx[i]});
    end
    for (int m = 0; m < 5; m++) begin
      for (int r = 0; r < 4; r++) begin
        i_des_model.set_mode(3'(m), r[0], r[1]);
        settle(2);
        chk_val(bc_toggle_budget_khz, 12'(budget(m, r)));
      end
    end
    close_out();
  end
  initial begin
    #100us;
    error_cnt++;
    close_out();
  end
endmodule // tb
`default_nettype wire
